// ---- shared/ionc_pkg.sv ----
// Package: map, encodings and sequencer types of the inertial output and command registers
// Contract
// - Accel x, y, z read-only at 0x0A/0x0C/0x0E.
// - Accel signed, 1200 counts per g.
// - Mag x, y, z signed at 0x10-0x14.
// - Lowest four mag bits idle at 51.2 SPS.
// - Decimation setting activates that many low bits.
// - Pressure unsigned at 0x16, 20 ubar/count.
// - Temperature 12-bit signed, upper nibble unused.
// - Command word write-only, resets to zero.
// - Bits 7 reset, 3 flash, 1 restore, 0 bias.
// - Written one starts function, self-clears when done.
// - Frame 0xBE08 triggers nonvolatile backup.
// - Reload controls from flash before new data.
// - Read: address frame, data next frame.
// - Byte writes, low byte at even address.
package ionc_pkg;

   localparam int unsigned DATA_W       = 16;
   localparam int unsigned ADDR_W       = 7;
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned RW_BIT       = 15;
   localparam int unsigned TEMP_W       = 12;
   localparam int unsigned MAG_RAW_LSBS = 4;
   localparam int unsigned DEC_W        = 5;

   localparam logic [6:0] OFF_ACCEL_X  = 7'h0a;
   localparam logic [6:0] OFF_ACCEL_Y  = 7'h0c;
   localparam logic [6:0] OFF_ACCEL_Z  = 7'h0e;
   localparam logic [6:0] OFF_MAG_X    = 7'h10;
   localparam logic [6:0] OFF_MAG_Y    = 7'h12;
   localparam logic [6:0] OFF_MAG_Z    = 7'h14;
   localparam logic [6:0] OFF_PRESSURE = 7'h16;
   localparam logic [6:0] OFF_TEMP     = 7'h18;
   localparam logic [6:0] OFF_CMD_LO   = 7'h3e;
   localparam logic [6:0] OFF_CMD_HI   = 7'h3f;

   localparam int unsigned CMD_BIT_SOFT_RESET = 7;
   localparam int unsigned CMD_BIT_FLASH      = 3;
   localparam int unsigned CMD_BIT_RESTORE    = 1;
   localparam int unsigned CMD_BIT_BIAS       = 0;

   localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
   localparam logic [15:0] OUT_RESET_VAL = 16'h0000;
   localparam logic [15:0] NO_DATA       = 16'h0000;
   localparam logic        PIN_IDLE      = 1'b1;

   // Encoding scales, for software that reads the words
   localparam int unsigned ACCEL_COUNTS_PER_G  = 1200;
   localparam int unsigned MAG_COUNTS_PER_MGS  = 7;
   localparam int unsigned PRESS_UBAR_PER_CNT  = 20;
   localparam real         TEMP_DEGC_PER_CNT   = 0.07386;
   localparam int          TEMP_ZERO_DEGC      = 31;

   typedef enum logic [2:0] {
      FN_BIAS, FN_RESTORE, FN_FLASH, FN_RELOAD, FN_RESET
   } ionc_func_t;
   localparam int unsigned FUNC_N = 5;

   typedef enum logic {S_IDLE, S_RUN} ionc_seq_t;

endpackage : ionc_pkg

// ---- shared/ionc_cmd_if.sv ----
// Interface: command byte writes and update hold between register file and sequencer
`timescale 1ns/1ps
interface ionc_cmd_if;
   logic       wr_lo;
   logic [7:0] wr_data;
   logic       hold;
   modport regs (output wr_lo, output wr_data, input hold);
   modport seq  (input wr_lo, input wr_data, output hold);
endinterface : ionc_cmd_if

// ---- hdl/ionc_cmd_seq.sv ----
// Module: self-clearing global command bits and their one-at-a-time sequencer
`timescale 1ns/1ps
module ionc_cmd_seq (
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   ionc_cmd_if.seq                             cmd,
   input  wire logic                           func_done,
   output logic      [ionc_pkg::FUNC_N-1:0]    func_start
);
   logic [ionc_pkg::FUNC_N-1:0] pend_q;
   logic [ionc_pkg::FUNC_N-1:0] pend_d;
   logic [ionc_pkg::FUNC_N-1:0] set_vec;
   logic [ionc_pkg::FUNC_N-1:0] clr_vec;
   ionc_pkg::ionc_seq_t         state_q;
   ionc_pkg::ionc_func_t        cur_q;
   logic                        hold_q;
   logic                        fin;

   assign fin = (state_q == ionc_pkg::S_RUN) && func_done;

   always_comb begin
      set_vec = '0;
      clr_vec = '0;
      if (cmd.wr_lo) begin
         set_vec[ionc_pkg::FN_BIAS]    = cmd.wr_data[ionc_pkg::CMD_BIT_BIAS];
         set_vec[ionc_pkg::FN_RESTORE] = cmd.wr_data[ionc_pkg::CMD_BIT_RESTORE];
         set_vec[ionc_pkg::FN_FLASH]   = cmd.wr_data[ionc_pkg::CMD_BIT_FLASH];
         set_vec[ionc_pkg::FN_RESET]   = cmd.wr_data[ionc_pkg::CMD_BIT_SOFT_RESET];
      end
      if (fin) begin
         clr_vec[cur_q] = 1'b1;
         if (cur_q == ionc_pkg::FN_FLASH) begin
            set_vec[ionc_pkg::FN_RELOAD] = 1'b1;
         end
      end
      // A set in the clearing cycle wins
      pend_d = (pend_q & ~clr_vec) | set_vec;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= '0;
         hold_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         hold_q <= pend_d[ionc_pkg::FN_FLASH] | pend_d[ionc_pkg::FN_RELOAD];
      end
   end

   // Reset first, then the reload that must finish before new data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ionc_pkg::S_IDLE;
         cur_q      <= ionc_pkg::FN_BIAS;
         func_start <= '0;
      end else begin
         func_start <= '0;
         case (state_q)
            ionc_pkg::S_IDLE: begin
               if (|pend_q) begin
                  state_q <= ionc_pkg::S_RUN;
                  if (pend_q[ionc_pkg::FN_RESET]) cur_q <= ionc_pkg::FN_RESET;
                  else if (pend_q[ionc_pkg::FN_RELOAD]) cur_q <= ionc_pkg::FN_RELOAD;
                  else if (pend_q[ionc_pkg::FN_BIAS]) cur_q <= ionc_pkg::FN_BIAS;
                  else if (pend_q[ionc_pkg::FN_RESTORE]) cur_q <= ionc_pkg::FN_RESTORE;
                  else cur_q <= ionc_pkg::FN_FLASH;
                  if (pend_q[ionc_pkg::FN_RESET]) func_start[ionc_pkg::FN_RESET] <= 1'b1;
                  else if (pend_q[ionc_pkg::FN_RELOAD]) func_start[ionc_pkg::FN_RELOAD] <= 1'b1;
                  else if (pend_q[ionc_pkg::FN_BIAS]) func_start[ionc_pkg::FN_BIAS] <= 1'b1;
                  else if (pend_q[ionc_pkg::FN_RESTORE]) func_start[ionc_pkg::FN_RESTORE] <= 1'b1;
                  else func_start[ionc_pkg::FN_FLASH] <= 1'b1;
               end
            end
            ionc_pkg::S_RUN: begin
               if (func_done) state_q <= ionc_pkg::S_IDLE;
            end
            default: state_q <= ionc_pkg::S_IDLE;
         endcase
      end
   end

   assign cmd.hold = hold_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_start_onehot: assert property ($onehot0(func_start))
      else $error("more than one command function started");
   chk_clear_on_done: assert property (fin && !set_vec[cur_q] |=> !pend_q[$past(cur_q)])
      else $error("command bit not cleared after completion");
   chk_flash_reload: assert property (fin && cur_q == ionc_pkg::FN_FLASH
      |=> pend_q[ionc_pkg::FN_RELOAD] ##1 hold_q)
      else $error("flash backup not followed by control reload");
   cov_flash_seq: cover property (fin && cur_q == ionc_pkg::FN_FLASH);
   cov_soft_reset: cover property (func_start[ionc_pkg::FN_RESET]);

endmodule : ionc_cmd_seq

// ---- hdl/ionc_regs.sv ----
// Module: serial-accessed sensor output registers and global command register
`timescale 1ns/1ps
module ionc_regs #(
   parameter int unsigned MAG_IDLE_LSBS = ionc_pkg::MAG_RAW_LSBS
) (
   input  wire logic                              clk,
   input  wire logic                              nrst,
   input  wire logic                              sclk,
   input  wire logic                              cs_n,
   input  wire logic                              mosi,
   output logic                                   miso,
   output logic                                   miso_oe,
   input  wire logic                              sample_strobe,
   input  wire logic [ionc_pkg::DATA_W-1:0]       accel_x_in,
   input  wire logic [ionc_pkg::DATA_W-1:0]       accel_y_in,
   input  wire logic [ionc_pkg::DATA_W-1:0]       accel_z_in,
   input  wire logic [ionc_pkg::DATA_W-1:0]       magfield_x_in,
   input  wire logic [ionc_pkg::DATA_W-1:0]       magfield_y_in,
   input  wire logic [ionc_pkg::DATA_W-1:0]       magfield_z_in,
   input  wire logic [ionc_pkg::DATA_W-1:0]       pressure_in,
   input  wire logic [ionc_pkg::TEMP_W-1:0]       temp_in,
   input  wire logic [ionc_pkg::DEC_W-1:0]        sample_period_decimation,
   input  wire logic                              func_done,
   output logic                                   bias_corr_start,
   output logic                                   cal_restore_start,
   output logic                                   flash_backup_start,
   output logic                                   flash_reload_start,
   output logic                                   soft_reset_start,
   output logic                                   updates_held
);
   initial begin
      if (MAG_IDLE_LSBS == 0 || MAG_IDLE_LSBS > 15) begin
         $error("MAG_IDLE_LSBS must be 1 to 15");
      end
   end

   localparam int unsigned DW = ionc_pkg::DATA_W;

   // Reset release and pin synchronisers
   logic rst_s1_q, rst_n_q;
   logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic mosi_s1_q, mosi_s2_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sclk_s1_q <= ionc_pkg::PIN_IDLE;
         sclk_s2_q <= ionc_pkg::PIN_IDLE;
         sclk_s3_q <= ionc_pkg::PIN_IDLE;
         cs_s1_q   <= ionc_pkg::PIN_IDLE;
         cs_s2_q   <= ionc_pkg::PIN_IDLE;
         cs_s3_q   <= ionc_pkg::PIN_IDLE;
         mosi_s1_q <= 1'b0;
         mosi_s2_q <= 1'b0;
      end else begin
         sclk_s1_q <= sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_s1_q   <= cs_n;
         cs_s2_q   <= cs_s1_q;
         cs_s3_q   <= cs_s2_q;
         mosi_s1_q <= mosi;
         mosi_s2_q <= mosi_s1_q;
      end
   end

   logic sclk_rise, sclk_fall, cs_fall, sel;
   assign sel       = !cs_s2_q;
   assign sclk_rise = sel && sclk_s2_q && !sclk_s3_q;
   assign sclk_fall = sel && !sclk_s2_q && sclk_s3_q;
   assign cs_fall   = !cs_s2_q && cs_s3_q;

   // Output registers
   logic [DW-1:0] accel_x_q, accel_y_q, accel_z_q;
   logic [DW-1:0] mag_x_q, mag_y_q, mag_z_q;
   logic [DW-1:0] pressure_q, temp_q;
   logic [DW-1:0] mag_mask;
   ionc_cmd_if    cmd ();

   // Each decimation step wakes one more of the idle low bits
   function automatic logic [DW-1:0] mag_keep(input logic [ionc_pkg::DEC_W-1:0] dec);
      logic [DW-1:0] m;
      m = '1;
      for (int i = 0; i < MAG_IDLE_LSBS; i++) begin
         if (i + 32'(dec) < MAG_IDLE_LSBS) m[i] = 1'b0;
      end
      return m;
   endfunction : mag_keep

   assign mag_mask = mag_keep(sample_period_decimation);

   // All eight words load on one strobe, so no read mixes two samples
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         accel_x_q  <= ionc_pkg::OUT_RESET_VAL;
         accel_y_q  <= ionc_pkg::OUT_RESET_VAL;
         accel_z_q  <= ionc_pkg::OUT_RESET_VAL;
         mag_x_q    <= ionc_pkg::OUT_RESET_VAL;
         mag_y_q    <= ionc_pkg::OUT_RESET_VAL;
         mag_z_q    <= ionc_pkg::OUT_RESET_VAL;
         pressure_q <= ionc_pkg::OUT_RESET_VAL;
         temp_q     <= ionc_pkg::OUT_RESET_VAL;
      end else if (sample_strobe && !cmd.hold) begin
         accel_x_q  <= accel_x_in;
         accel_y_q  <= accel_y_in;
         accel_z_q  <= accel_z_in;
         mag_x_q    <= magfield_x_in & mag_mask;
         mag_y_q    <= magfield_y_in & mag_mask;
         mag_z_q    <= magfield_z_in & mag_mask;
         pressure_q <= pressure_in;
         temp_q     <= {{(DW - ionc_pkg::TEMP_W){1'b0}}, temp_in};
      end
   end

   // Odd addresses name the upper byte of the same word
   function automatic logic [DW-1:0] read_word(input logic [ionc_pkg::ADDR_W-1:0] a);
      logic [ionc_pkg::ADDR_W-1:0] w;
      w = {a[ionc_pkg::ADDR_W-1:1], 1'b0};
      case (w)
         ionc_pkg::OFF_ACCEL_X:  read_word = accel_x_q;
         ionc_pkg::OFF_ACCEL_Y:  read_word = accel_y_q;
         ionc_pkg::OFF_ACCEL_Z:  read_word = accel_z_q;
         ionc_pkg::OFF_MAG_X:    read_word = mag_x_q;
         ionc_pkg::OFF_MAG_Y:    read_word = mag_y_q;
         ionc_pkg::OFF_MAG_Z:    read_word = mag_z_q;
         ionc_pkg::OFF_PRESSURE: read_word = pressure_q;
         ionc_pkg::OFF_TEMP:     read_word = temp_q;
         ionc_pkg::OFF_CMD_LO:   read_word = ionc_pkg::NO_DATA;
         default:                read_word = ionc_pkg::NO_DATA;
      endcase
   endfunction : read_word

   // Serial frame engine, clock idles high, sample on rise, shift on fall
   logic [4:0]    bit_cnt_q;
   logic [DW-1:0] rx_q, tx_q, rd_word_q;
   logic [DW-1:0] frame;
   logic          frame_done;
   logic          miso_q, miso_oe_q;
   logic          wr_lo_q;
   logic [7:0]    wr_data_q;

   assign frame      = {rx_q[DW-2:0], mosi_s2_q};
   assign frame_done = sclk_rise && (bit_cnt_q == 5'(ionc_pkg::FRAME_BITS - 1));

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bit_cnt_q <= '0;
         rx_q      <= '0;
      end else if (!sel) begin
         bit_cnt_q <= '0; // Partial frames are dropped
      end else if (sclk_rise) begin
         rx_q      <= frame;
         bit_cnt_q <= frame_done ? 5'd0 : bit_cnt_q + 5'd1;
      end
   end

   // Word is snapshotted at request time and shifted out next frame
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_word_q <= ionc_pkg::NO_DATA;
         tx_q      <= ionc_pkg::NO_DATA;
      end else if (frame_done) begin
         rd_word_q <= frame[ionc_pkg::RW_BIT] ? ionc_pkg::NO_DATA
                                              : read_word(frame[14:8]);
         tx_q      <= frame[ionc_pkg::RW_BIT] ? ionc_pkg::NO_DATA
                                              : read_word(frame[14:8]);
      end else if (cs_fall) begin
         tx_q <= rd_word_q;
      end else if (sclk_fall) begin
         tx_q <= {tx_q[DW-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         miso_q    <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_oe_q <= sel;
         if (sclk_fall) miso_q <= tx_q[DW-1];
      end
   end

   // Byte writes, only the low command byte has any function
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_lo_q   <= 1'b0;
         wr_data_q <= ionc_pkg::CMD_RESET_VAL[7:0];
      end else begin
         wr_lo_q <= frame_done && frame[ionc_pkg::RW_BIT]
                    && frame[14:8] == ionc_pkg::OFF_CMD_LO;
         if (frame_done) wr_data_q <= frame[7:0];
      end
   end

   assign cmd.wr_lo   = wr_lo_q;
   assign cmd.wr_data = wr_data_q;

   logic [ionc_pkg::FUNC_N-1:0] func_start;

   ionc_cmd_seq u_seq (
      .clk        (clk),
      .rst_n      (rst_n_q),
      .cmd        (cmd.seq),
      .func_done  (func_done),
      .func_start (func_start)
   );

   assign miso               = miso_q;
   assign miso_oe            = miso_oe_q;
   assign bias_corr_start    = func_start[ionc_pkg::FN_BIAS];
   assign cal_restore_start  = func_start[ionc_pkg::FN_RESTORE];
   assign flash_backup_start = func_start[ionc_pkg::FN_FLASH];
   assign flash_reload_start = func_start[ionc_pkg::FN_RELOAD];
   assign soft_reset_start   = func_start[ionc_pkg::FN_RESET];
   assign updates_held       = cmd.hold;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_q);

   chk_accel_load: assert property (sample_strobe && !cmd.hold
      |=> accel_x_q == $past(accel_x_in) && accel_z_q == $past(accel_z_in))
      else $error("acceleration word not loaded on sample");
   chk_hold_freeze: assert property (cmd.hold |=> $stable(accel_y_q) && $stable(pressure_q))
      else $error("output words changed during flash sequence");
   chk_mag_idle_bits: assert property (sample_strobe && !cmd.hold
      && sample_period_decimation == 5'd0 |=> mag_x_q[3:0] == 4'h0)
      else $error("idle magnetometer bits active at full rate");
   chk_mag_decim: assert property (sample_strobe && !cmd.hold
      && sample_period_decimation == 5'd2
      |=> mag_y_q[1:0] == 2'b00 && mag_y_q[15:2] == $past(magfield_y_in[15:2]))
      else $error("decimation did not wake the right bits");
   chk_temp_upper: assert property (temp_q[15:12] == 4'h0)
      else $error("unused temperature bits set");
   chk_press_load: assert property (sample_strobe && !cmd.hold
      |=> pressure_q == $past(pressure_in))
      else $error("pressure word not loaded on sample");
   chk_read_answer: assert property (frame_done && !frame[ionc_pkg::RW_BIT]
      && frame[14:8] == ionc_pkg::OFF_MAG_Z |=> rd_word_q == $past(mag_z_q))
      else $error("read returned wrong word");
   chk_cmd_unread: assert property (frame_done && frame[14:8] == ionc_pkg::OFF_CMD_LO
      |=> rd_word_q == ionc_pkg::NO_DATA)
      else $error("command word readable");
   chk_cmd_write: assert property (frame_done && frame == 16'hbe08
      |=> wr_lo_q ##2 updates_held)
      else $error("flash command frame not taken");
   chk_words_whole: assert property (sample_strobe && !cmd.hold
      |=> temp_q == {4'h0, $past(temp_in)}
      && mag_z_q == ($past(magfield_z_in) & $past(mag_mask)))
      else $error("output words not loaded together");

   cov_read_accel: cover property (frame_done && frame[14:8] == ionc_pkg::OFF_ACCEL_X);
   cov_reset_frame: cover property (frame_done && frame == 16'hbe80);
   cov_held_sample: cover property (sample_strobe && cmd.hold);

endmodule : ionc_regs

// ---- dv/ionc_spi_master.sv ----
// Partner model: serial port master sending 16-bit mode 3 frames, MSB first
`timescale 1ns/1ps
module ionc_spi_master #(
   parameter int HALF = 5
) (
   input  wire logic clk,
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      mosi = 1'b1;
   end

   // One frame with select around it; clock stands high between frames
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      @(posedge clk);
      #10 cs_n = 1'b0;
      repeat (HALF) @(posedge clk);
      for (int i = 15; i >= 0; i--) begin
         #10 sclk = 1'b0;
         mosi = tx[i];
         repeat (HALF) @(posedge clk);
         #10 sclk = 1'b1;
         rx[i] = miso;
         repeat (HALF) @(posedge clk);
      end
      #10 cs_n = 1'b1;
      // Deselected data line carries no stale bit
      mosi = ~tx[0];
      repeat (2 * HALF) @(posedge clk);
   endtask : xfer
endmodule : ionc_spi_master

// ---- dv/inertial_output_and_command_regs_bench.sv ----
// Testbench: sensor word reads, command triggers and update hold over the serial port
`timescale 1ns/1ps
module inertial_output_and_command_regs_bench;
   logic        clk, nrst, sample_strobe, func_done, held;
   logic        sclk, cs_n, mosi, miso, miso_oe, miso_w, miso_last;
   logic [15:0] ax, ay, az, mx, my, mz, pr, v;
   logic [11:0] tp;
   logic [4:0]  dec;
   wire  [4:0]  st;
   logic [15:0] model [8];
   logic [6:0]  offs [8] = '{ionc_pkg::OFF_ACCEL_X, ionc_pkg::OFF_ACCEL_Y,
      ionc_pkg::OFF_ACCEL_Z, ionc_pkg::OFF_MAG_X, ionc_pkg::OFF_MAG_Y,
      ionc_pkg::OFF_MAG_Z, ionc_pkg::OFF_PRESSURE, ionc_pkg::OFF_TEMP};
   int unsigned pc [5] = '{default: 0};
   int          n_errors, n_checks, tot;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Released data line shows the inverse of its last bit
   always @(posedge clk) if (miso_oe === 1'b1) miso_last <= miso;
   assign miso_w = (miso_oe === 1'b1) ? miso : ~miso_last;
   always @(posedge clk) for (int k = 0; k < 5; k++) if (st[k] === 1'b1) pc[k]++;

   ionc_spi_master ionc_spi_master_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso_w));

   ionc_regs ionc_regs_i (
      .clk                      (clk),
      .nrst                     (nrst),
      .sclk                     (sclk),
      .cs_n                     (cs_n),
      .mosi                     (mosi),
      .miso                     (miso),
      .miso_oe                  (miso_oe),
      .sample_strobe            (sample_strobe),
      .accel_x_in               (ax),
      .accel_y_in               (ay),
      .accel_z_in               (az),
      .magfield_x_in            (mx),
      .magfield_y_in            (my),
      .magfield_z_in            (mz),
      .pressure_in              (pr),
      .temp_in                  (tp),
      .sample_period_decimation (dec),
      .func_done                (func_done),
      .bias_corr_start          (st[0]),
      .cal_restore_start        (st[1]),
      .flash_backup_start       (st[2]),
      .flash_reload_start       (st[3]),
      .soft_reset_start         (st[4]),
      .updates_held             (held)
   );

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Magnet words lose their idle low bits below decimation four
   function automatic logic [15:0] expw(input int i);
      int n;
      n = (i >= 3 && i <= 5 && dec < 5'h04) ? 4 - int'(dec) : 0;
      return model[i] & (16'hffff << n);
   endfunction : expw

   function automatic int total();
      return pc[0] + pc[1] + pc[2] + pc[3] + pc[4];
   endfunction : total

   task automatic wr(input logic [6:0] a, input logic [7:0] b);
      logic [15:0] r;
      ionc_spi_master_i.xfer({1'b1, a, b}, r);
   endtask : wr

   // Chained reads: each frame asks for the next word, odd addresses every other time
   task automatic read_all();
      for (int i = 0; i <= 8; i++) begin
         ionc_spi_master_i.xfer({1'b0, offs[i % 8] | 7'(i & 1), 8'h00}, v);
         if (i > 0) check("sensor word", v, expw(i - 1));
      end
   endtask : read_all

   task automatic load(input bit take, input bit ones);
      @(posedge clk);
      #10;
      {ax, ay, az, mx} = {$urandom, $urandom};
      {my, mz, pr} = 48'({$urandom, $urandom});
      tp = 12'($urandom);
      if (ones) {ax, ay, az, mx, my, mz, pr, tp} = '1;
      sample_strobe = 1'b1;
      @(posedge clk);
      #10 sample_strobe = 1'b0;
      if (take) model = '{ax, ay, az, mx, my, mz, pr, {4'h0, tp}};
   endtask : load

   // Waits on the start counter, so a pulse seen before the call still counts
   task automatic waitp(input int k, input int unsigned base);
      for (int t = 0; t < 100 && pc[k] == base; t++) begin
         @(posedge clk);
         #10;
      end
   endtask : waitp

   task automatic done();
      @(posedge clk);
      #10 func_done = 1'b1;
      @(posedge clk);
      #10 func_done = 1'b0;
   endtask : done

   task automatic cmd(input logic [7:0] b, input int k);
      int unsigned b4;
      b4 = pc[k];
      tot = total();
      wr(ionc_pkg::OFF_CMD_LO, b);
      waitp(k, b4);
      done();
      check("start count", 16'(pc[k]), 16'(b4 + 1));
      check("all starts", 16'(total()), 16'(tot + 1));
   endtask : cmd

   initial begin
      #8_000_000;
      n_errors++;
      test_done();
   end

   initial begin
      logic [7:0] cb [3] = '{8'h80, 8'h01, 8'h02};
      int         ck [3] = '{4, 0, 1};
      logic [15:0] e;
      int unsigned b2, b3;
      nrst = 1'b0;
      sample_strobe = 1'b0;
      func_done = 1'b0;
      dec = 5'h00;
      {ax, ay, az, mx, my, mz, pr, tp} = '0;
      n_errors = 0;
      n_checks = 0;
      foreach (model[i]) model[i] = ionc_pkg::OUT_RESET_VAL;
      void'($urandom(1));
      repeat (6) @(posedge clk);
      #10 nrst = 1'b1;
      repeat (4) @(posedge clk);
      read_all();
      for (int d = 0; d < 7; d++) begin
         dec = (d == 6) ? 5'h1f : 5'(d);
         load(1'b1, d == 0);
         read_all();
      end
      // Read-only word and dead command bits must not react
      tot = total();
      wr(ionc_pkg::OFF_CMD_LO, 8'h74);
      wr(ionc_pkg::OFF_CMD_HI, 8'hff);
      wr(ionc_pkg::OFF_ACCEL_X, 8'h5a);
      check("dead bits", 16'(total()), 16'(tot));
      read_all();
      // Twice each: a second trigger only works if the bit cleared itself
      for (int r = 0; r < 6; r++) cmd(cb[r % 3], ck[r % 3]);
      // Backup then reload, samples ignored meanwhile
      tot = total();
      b2 = pc[2];
      b3 = pc[3];
      wr(ionc_pkg::OFF_CMD_LO, 8'h08);
      waitp(2, b2);
      check("held in backup", {15'h0, held}, 16'h0001);
      load(1'b0, 1'b0);
      done();
      waitp(3, b3);
      check("held in reload", {15'h0, held}, 16'h0001);
      done();
      repeat (2) @(posedge clk);
      check("held released", {15'h0, held}, 16'h0000);
      check("flash starts", 16'(total()), 16'(tot + 2));
      read_all();
      // A sample landing mid-frame must not tear the word being sent
      ionc_spi_master_i.xfer({1'b0, ionc_pkg::OFF_MAG_X, 8'h00}, v);
      e = expw(3);
      fork
         ionc_spi_master_i.xfer(16'h0000, v);
         begin
            repeat (60) @(posedge clk);
            load(1'b1, 1'b0);
         end
      join
      check("whole word", v, e);
      read_all();
      test_done();
   end
endmodule : inertial_output_and_command_regs_bench
